// ==== dv/tpg_rx_model.sv ====
// Far-side receiver model: keeps the qualified bits in arrival order
`default_nettype none
module tpg_rx_model (
  input wire logic clk,
  input wire logic rx_bit,
  input wire logic rx_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  logic q[$];
  // Capture on each qualified cycle
  always @(posedge clk) begin
    if (rx_valid) q.push_back(rx_bit);
  end
endmodule
`default_nettype wire

// ==== dv/tpg_top_sva.sv ====
// Port checker for the test pattern frame generator
`default_nettype none
module tpg_top_sva
  import tpg_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire tpg_pkg::tpg_src_e out_type,
  input wire logic pcm_run,
  input wire tpg_pkg::tpg_pcm_cfg_s pcm_cfg,
  input wire logic pcm_busy,
  input wire logic [15:0] frame_count,
  input wire logic frame_start,
  input wire logic tx_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // ----------------------------------------------------------------------
  // Settle time after reset release
  // ----------------------------------------------------------------------
  logic [2:0] up_q;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) up_q <= 3'h0;
    else if (up_q != 3'h7) up_q <= up_q + 3'h1;
  end
  wire logic settled = (up_q == 3'h7);
  // Busy and source selection
  property p_busy; pcm_busy == (pcm_run && out_type == TPG_SRC_PCM); endproperty
  a_busy: assert property (p_busy) else $error("busy wrong");
  property p_prn_valid; settled && out_type == TPG_SRC_PRN && $past(out_type) == TPG_SRC_PRN |-> tx_valid;
  endproperty
  a_prn_valid: assert property (p_prn_valid) else $error("random stream gap");
  property p_halt; (settled && out_type == TPG_SRC_PCM && !pcm_busy) [*3] |-> !tx_valid && !frame_start;
  endproperty
  a_halt: assert property (p_halt) else $error("bits while halted");
  // Framing
  property p_start_gap; frame_start |=> !frame_start [*8]; endproperty
  a_start_gap: assert property (p_start_gap) else $error("frame too short");
  property p_start_valid; frame_start |-> tx_valid; endproperty
  a_start_valid: assert property (p_start_valid) else $error("start without bit");
  // Frame counter
  property p_cnt_once; pcm_busy && $changed(frame_count) |=> (!pcm_busy || $stable(frame_count)) [*8];
  endproperty
  a_cnt_once: assert property (p_cnt_once) else $error("counter stepped twice");
  property p_range; settled && pcm_busy && $past(pcm_busy) |->
    frame_count >= pcm_cfg.count_min && frame_count <= pcm_cfg.count_max; endproperty
  a_range: assert property (p_range) else $error("counter out of range");
  property p_up; settled && pcm_busy && $past(pcm_busy) && !pcm_cfg.count_down && $changed(frame_count) |->
    ($past(frame_count) >= pcm_cfg.count_max ? frame_count == 16'(pcm_cfg.count_min)
    : frame_count == $past(frame_count) + 16'h1); endproperty
  a_up: assert property (p_up) else $error("up step wrong");
  property p_down; settled && pcm_busy && $past(pcm_busy) && pcm_cfg.count_down && $changed(frame_count) |->
    ($past(frame_count) <= 16'(pcm_cfg.count_min) ? frame_count == pcm_cfg.count_max
    : frame_count == $past(frame_count) - 16'h1); endproperty
  a_down: assert property (p_down) else $error("down step wrong");
  c_frame: cover property (frame_start);
  c_down: cover property (pcm_busy && pcm_cfg.count_down && $changed(frame_count));
  c_prn: cover property (out_type == TPG_SRC_PRN && tx_valid);
endmodule
bind tpg_top tpg_top_sva tpg_top_sva_i (.ref_clk(ref_clk), .reset_n(reset_n), .out_type(out_type),
  .pcm_run(pcm_run), .pcm_cfg(pcm_cfg), .pcm_busy(pcm_busy), .frame_count(frame_count),
  .frame_start(frame_start), .tx_valid(tx_valid));
`default_nettype wire

// ==== dv/tpg_top_tb.sv ====
// Bench for the test pattern frame generator
`default_nettype none
module tpg_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import tpg_pkg::*;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  tpg_src_e out_type = TPG_SRC_PRN;
  tpg_prn_cfg_s prn_cfg = '0;
  tpg_pcm_cfg_s pcm_cfg = '0;
  tpg_instr_s prog_wdata = '0;
  logic [31:0] irig_time = '0;
  logic [31:0] seed = 32'h39a9d3fc;
  logic [5:0] prog_len = '0;
  logic [4:0] prog_addr = '0;
  logic pcm_run = 1'b0;
  logic prog_we = 1'b0;
  logic pcm_busy, frame_start, tx_bit, tx_valid;
  logic [15:0] frame_count;
  int err_count = 0;
  int num_checks = 0;
  int deg[7] = '{7, 9, 11, 15, 20, 23, 31};
  int tap[7] = '{6, 5, 9, 14, 17, 18, 28};
  tpg_top tpg_top_i (.ref_clk(ref_clk), .reset_n(reset_n), .out_type(out_type), .prn_cfg(prn_cfg),
    .irig_time(irig_time), .pcm_run(pcm_run), .pcm_cfg(pcm_cfg), .prog_len(prog_len), .prog_we(prog_we),
    .prog_addr(prog_addr), .prog_wdata(prog_wdata), .pcm_busy(pcm_busy), .frame_count(frame_count),
    .frame_start(frame_start), .tx_bit(tx_bit), .tx_valid(tx_valid));
  tpg_rx_model tpg_rx_model_i (.clk(ref_clk), .rx_bit(tx_bit), .rx_valid(tx_valid));
  initial forever #2.5 ref_clk = ~ref_clk;
  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] take(input int w);
    logic [31:0] v;
    v = '0;
    repeat (w) v = {v[30:0], tpg_rx_model_i.q.pop_front()};
    return v;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks=%0d errors=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wait_bits(input int n);
    int k;
    k = 0;
    while (tpg_rx_model_i.q.size() < n && k < 9000) begin
      @(posedge ref_clk);
      k++;
    end
    if (k >= 9000) check(32'h1, 32'h0);
  endtask
  // Expected word at frame position i for counter value c
  function automatic logic [15:0] exp_word(input int i, input int n, input logic [15:0] c,
    input logic [15:0] d0, input logic [15:0] d1, input logic [15:0] d2, input logic [15:0] g);
    int k;
    k = i % (n + 5);
    if (k == 0) return d0;
    if (k == 1) return d1;
    if (k == 2) return c;
    if (k == n + 4) return d2;
    return g;
  endfunction
  // Counter value after one frame step, wrapping at the limits
  function automatic logic [15:0] step_count(input logic down, input logic [15:0] c, input logic [15:0] lo,
    input logic [15:0] hi);
    if (down) return (c <= lo) ? hi : c - 16'h0001;
    return (c >= hi) ? lo : c + 16'h0001;
  endfunction
  task automatic wr(input logic [4:0] a, input tpg_op_e op, input logic [15:0] d);
    @(posedge ref_clk);
    prog_we <= 1'b1;
    prog_addr <= a;
    prog_wdata <= '{op, d};
  endtask
  // Capture 120 random bits; hit bits say which recurrence held
  task automatic prn_case(input int s, input logic rev, output logic [1:0] hit);
    logic b[120];
    int d, t, ones;
    hit = 2'b11;
    ones = 0;
    prn_cfg <= '{tpg_len_e'(s), rev, 1'b0};
    repeat (6) @(posedge ref_clk);
    @(negedge ref_clk) tpg_rx_model_i.q.delete();
    wait_bits(120);
    d = deg[s];
    t = tap[s];
    for (int n = 0; n < 120; n++) b[n] = tpg_rx_model_i.q[n];
    for (int n = 31; n < 120; n++) begin
      ones += int'(b[n]);
      if (b[n] !== (b[n - d] ^ b[n - t])) hit[0] = 1'b0;
      if (b[n] !== (b[n - d] ^ b[n - d + t])) hit[1] = 1'b0;
    end
    if (ones == 0) hit = 2'b00;
  endtask
  // Program a frame, run three frames, compare every word
  task automatic pcm_case(input logic down, input int w, input int nf);
    int n;
    logic [15:0] d0, d1, d2, g, c, e, cmin, cmax;
    n = int'(rnd() % 7);
    d0 = 16'(rnd());
    d1 = 16'(rnd());
    d2 = 16'(rnd());
    g = 16'(rnd());
    cmin = 16'(rnd() % 2);
    cmax = 16'(1 + rnd() % 3);
    out_type <= TPG_SRC_PCM;
    pcm_run <= 1'b0;
    prog_len <= 6'h06;
    pcm_cfg <= '{g, 5'(w), 13'(nf), down, cmin[0], cmax};
    wr(5'h00, TPG_OP_FRAME_SYNC, d0);
    wr(5'h01, TPG_OP_IMMEDIATE, d1);
    wr(5'h02, TPG_OP_FRAME_COUNT, 16'h0);
    wr(5'h03, TPG_OP_GENERAL, 16'h0);
    wr(5'h04, TPG_OP_REPEAT, 16'(n));
    wr(5'h05, TPG_OP_IMMEDIATE, d2);
    @(posedge ref_clk) prog_we <= 1'b0;
    @(negedge ref_clk) tpg_rx_model_i.q.delete();
    repeat (20) @(posedge ref_clk);
    check(tpg_rx_model_i.q.size(), 0);
    @(posedge ref_clk) pcm_run <= 1'b1;
    wr(5'h00, TPG_OP_IMMEDIATE, ~d0);
    pcm_cfg.general_word <= ~g;
    prn_cfg <= '{TPG_LEN_9, 1'b1, 1'b1};
    @(posedge ref_clk) prog_we <= 1'b0;
    wait_bits(3 * nf * w);
    for (int f = 0; f < 3; f++) begin
      c = down ? cmax : cmin;
      repeat (f) c = step_count(down, c, cmin, cmax);
      for (int i = 0; i < nf; i++) begin
        e = exp_word(i, n, c, d0, d1, d2, g);
        check(take(w), 32'(e & 16'((17'h1 << w) - 17'h1)));
      end
    end
    @(posedge ref_clk) pcm_run <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask
  // ----------------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------------
  initial begin
    logic [1:0] hf, hr;
    logic [31:0] v;
    logic found;
    repeat (10) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    pcm_run <= 1'b1;
    for (int s = 0; s < 7; s++) begin
      prn_case(s, 1'b0, hf);
      check(hf[0] ^ hf[1], 1);
      prn_case(s, 1'b1, hr);
      check(hr, {~hf});
    end
    irig_time <= rnd();
    prn_cfg <= '{TPG_LEN_31, 1'b0, 1'b1};
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk) tpg_rx_model_i.q.delete();
    wait_bits(1200);
    found = 1'b0;
    for (int n = 0; n < 1168; n++) begin
      v = '0;
      for (int k = 0; k < 32; k++) v = {v[30:0], tpg_rx_model_i.q[n + k]};
      if (v === irig_time) found = 1'b1;
    end
    check(found, 1);
    pcm_case(1'b0, 4, 8);
    pcm_case(1'b1, 16, int'(8 + rnd() % 9));
    repeat (2) pcm_case(1'(rnd()), int'(4 + rnd() % 13), int'(8 + rnd() % 9));
    stop_test();
  end
  initial begin
    repeat (30000) @(posedge ref_clk);
    err_count++;
    stop_test();
  end
endmodule
`default_nettype wire

// ==== hdl/tpg_prbs.sv ====
// Maximal-length shift register for the pseudo-random source, forward or reverse
`default_nettype none
module tpg_prbs
  import tpg_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic advance,
  input wire tpg_pkg::tpg_len_e len_sel,
  input wire logic reverse,
  output logic bit_out
);

  logic [30:0] lfsr_q;
  logic [30:0] lfsr_d;
  logic [30:0] mask;
  tpg_len_e len_q;
  logic [4:0] deg;
  logic [4:0] tap;
  logic top_bit;

  // Low d bits set; trims the register to the selected degree
  function automatic logic [30:0] len_mask(input logic [4:0] d);
    return 31'(({32'h0, 1'b1} << d) - 33'h1);
  endfunction

  // ----------------------------------------------------------------------
  // Next state in either direction
  // ----------------------------------------------------------------------
  always_comb begin
    deg = tpg_degree(len_sel);
    tap = tpg_tap(len_sel);
    mask = len_mask(deg);
    top_bit = lfsr_q[5'(deg - 5'h01)] ^ lfsr_q[5'(tap - 5'h01)];
    if (reverse) begin
      // Undo one forward step; emits the bit a forward run dropped [R3]
      top_bit = lfsr_q[0] ^ lfsr_q[tap];
      lfsr_d = ((lfsr_q >> 1) | (31'(top_bit) << (deg - 5'h01))) & mask;
    end else begin
      lfsr_d = ((lfsr_q << 1) | 31'(top_bit)) & mask; // [R19]
    end
  end

  // ----------------------------------------------------------------------
  // Register; reseeds non-zero when the length changes
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lfsr_q <= TPG_LFSR_SEED;
      len_q <= TPG_LEN_7;
      bit_out <= 1'b0;
    end else begin
      len_q <= len_sel;
      if (len_q != len_sel) begin
        lfsr_q <= TPG_LFSR_SEED & mask; // [R19]
      end else if (advance) begin
        lfsr_q <= lfsr_d; // [R2]
        bit_out <= reverse ? top_bit : lfsr_q[5'(deg - 5'h01)];
      end
    end
  end

endmodule
`default_nettype wire

// ==== hdl/tpg_top.sv ====
// Test pattern frame generator: pseudo-random or programmed PCM frame bit stream
`default_nettype none
// Notes on behaviour
// [R1] Pseudo-random settings only matter when the pseudo-random source is selected.
// [R2] Seven sequence lengths: degrees 7, 9, 11, 15, 20, 23, 31.
// [R3] Direction picks forward or reverse generation of the pattern.
// [R4] With time insertion on, the time value is spliced into the random stream.
// [R5] Output carries random or PCM data, never both, per type selection.
// [R6] PCM data only flows while run is set; halted means nothing output.
// [R7] One general word value, placed into frames where the program says.
// [R8] Word width 4 to 16 bits; every word serialised at that width.
// [R9] Frame length 8 to 4096 words; frames follow back to back.
// [R10] Frame counter updates exactly once per transmitted frame.
// [R11] Direction setting makes the frame counter count up or down.
// [R12] Lowest counter value is 0 or 1 only.
// [R13] Highest counter value is 1 to 0xffff.
// [R14] PCM settings and program are frozen while the PCM program runs; prog_len is not frozen and is read live by the sequencer.
// [R15] PCM program runs only when type selects PCM, whatever run says.
// [R16] Program of up to 32 instructions: sync, immediate, counter, general, repeat.
// [R17] Program words past the frame length are dropped.
// [R18] Counter wraps from highest to lowest and back, per direction.
// [R19] Each length comes from a maximal shift register seeded non-zero.
module tpg_top
  import tpg_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire tpg_pkg::tpg_src_e out_type,
  input wire tpg_pkg::tpg_prn_cfg_s prn_cfg,
  input wire logic [31:0] irig_time,
  input wire logic pcm_run,
  input wire tpg_pkg::tpg_pcm_cfg_s pcm_cfg,
  input wire logic [5:0] prog_len,
  input wire logic prog_we,
  input wire logic [4:0] prog_addr,
  input wire tpg_pkg::tpg_instr_s prog_wdata,
  output logic pcm_busy,
  output logic [15:0] frame_count,
  output logic frame_start,
  output logic tx_bit,
  output logic tx_valid
);

  // ----------------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------------
  logic rst_meta_q;
  logic rst_n_q;

  // Two flops release the asynchronous reset
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  tpg_instr_s prog_q [TPG_PROG_DEPTH];
  tpg_pcm_cfg_s cfg_q;
  tpg_state_e state_q;
  logic running;
  logic [4:0] pc_q;
  logic [15:0] rep_q;
  logic [15:0] word_q;
  logic [15:0] last_q;
  logic [4:0] bit_idx_q;
  logic [12:0] word_idx_q;
  logic [15:0] cnt_q;
  logic frame_end;
  logic prn_sel;
  logic prn_bit;
  logic prn_adv;
  logic ins_q;
  logic [4:0] ins_idx_q;
  logic [31:0] time_q;
  logic [10:0] gap_q;
  tpg_instr_s inst;
  logic [15:0] inst_word;

  // PCM program only runs when PCM is the selected type [R15]
  assign running = pcm_run && (out_type == TPG_SRC_PCM); // [R6]
  assign pcm_busy = running;
  assign prn_sel = (out_type == TPG_SRC_PRN); // [R1]
  assign frame_count = cnt_q;

  // ----------------------------------------------------------------------
  // Frozen settings and program store
  // ----------------------------------------------------------------------
  // Settings follow the inputs only while halted, clamped to legal ranges
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cfg_q <= '{16'h0000, TPG_WIDTH_MIN, TPG_FLEN_MIN, 1'b0, 1'b0, TPG_CMAX_MIN};
    end else if (!running) begin // [R14]
      cfg_q <= pcm_cfg; // [R7] [R12]
      cfg_q.bits_per_word <= (pcm_cfg.bits_per_word < TPG_WIDTH_MIN) ? TPG_WIDTH_MIN :
                             (pcm_cfg.bits_per_word > TPG_WIDTH_MAX) ? TPG_WIDTH_MAX :
                             pcm_cfg.bits_per_word; // [R8]
      cfg_q.words_per_frame <= (pcm_cfg.words_per_frame < TPG_FLEN_MIN) ? TPG_FLEN_MIN :
                               (pcm_cfg.words_per_frame > TPG_FLEN_MAX) ? TPG_FLEN_MAX :
                               pcm_cfg.words_per_frame; // [R9]
      cfg_q.count_max <= (pcm_cfg.count_max < TPG_CMAX_MIN) ? TPG_CMAX_MIN : pcm_cfg.count_max; // [R13]
    end
  end

  // Program writes are ignored while running
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      for (int i = 0; i < TPG_PROG_DEPTH; i++) begin
        prog_q[i] <= '{TPG_OP_IMMEDIATE, 16'h0000};
      end
    end else if (prog_we && !running) begin // [R14]
      prog_q[prog_addr] <= prog_wdata; // [R16]
    end
  end

  // ----------------------------------------------------------------------
  // Frame program sequencer
  // ----------------------------------------------------------------------
  // Word value for the instruction at the program counter
  always_comb begin
    inst = prog_q[pc_q];
    unique case (inst.op)
      TPG_OP_FRAME_SYNC: inst_word = inst.data;
      TPG_OP_FRAME_COUNT: inst_word = cnt_q;
      TPG_OP_GENERAL: inst_word = cfg_q.general_word; // [R7]
      default: inst_word = inst.data;
    endcase
  end

  assign frame_end = (state_q == TPG_ST_FETCH) && (word_idx_q == cfg_q.words_per_frame);

  // Fetch a word, then shift it out at the programmed width
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q <= TPG_ST_IDLE;
      pc_q <= 5'h00;
      rep_q <= 16'h0000;
      word_q <= 16'h0000;
      last_q <= 16'h0000;
      bit_idx_q <= 5'h00;
      word_idx_q <= 13'h0000;
    end else if (!running) begin
      state_q <= TPG_ST_IDLE;
      pc_q <= 5'h00;
      rep_q <= 16'h0000;
      word_idx_q <= 13'h0000;
    end else begin
      unique case (state_q)
        TPG_ST_IDLE: begin
          state_q <= TPG_ST_FETCH;
        end
        TPG_ST_FETCH: begin
          if (frame_end) begin
            // Rest of the program is dropped; next frame starts at once
            pc_q <= 5'h00; // [R17] [R9]
            rep_q <= 16'h0000;
            word_idx_q <= 13'h0000;
          end else if (rep_q != 16'h0000) begin
            rep_q <= rep_q - 16'h0001; // [R16]
            word_q <= last_q;
            word_idx_q <= word_idx_q + 13'h0001;
            bit_idx_q <= 5'(cfg_q.bits_per_word - 5'h01);
            state_q <= TPG_ST_SHIFT;
          end else if ({1'b0, pc_q} >= prog_len) begin
            pc_q <= 5'h00; // Short program restarts to fill the frame
          end else begin
            pc_q <= 5'(pc_q + 5'h01);
            if (inst.op == TPG_OP_REPEAT) begin
              rep_q <= inst.data; // [R16]
            end else begin
              word_q <= inst_word;
              last_q <= inst_word;
              word_idx_q <= word_idx_q + 13'h0001;
              bit_idx_q <= 5'(cfg_q.bits_per_word - 5'h01);
              state_q <= TPG_ST_SHIFT;
            end
          end
        end
        TPG_ST_SHIFT: begin
          if (bit_idx_q == 5'h00) begin
            state_q <= TPG_ST_FETCH;
          end else begin
            bit_idx_q <= bit_idx_q - 5'h01; // [R8]
          end
        end
        default: begin
          state_q <= TPG_ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Frame counter
  // ----------------------------------------------------------------------
  // Steps once at each frame end, wrapping between the limits
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cnt_q <= TPG_CNT_RESET;
    end else if (!running) begin
      cnt_q <= cfg_q.count_down ? cfg_q.count_max : {15'h0000, cfg_q.count_min};
    end else if (frame_end) begin // [R10]
      if (cfg_q.count_down) begin // [R11]
        cnt_q <= (cnt_q <= {15'h0000, cfg_q.count_min}) ? cfg_q.count_max : cnt_q - 16'h0001; // [R18]
      end else begin
        cnt_q <= (cnt_q >= cfg_q.count_max) ? {15'h0000, cfg_q.count_min} : cnt_q + 16'h0001; // [R18]
      end
    end
  end

  // ----------------------------------------------------------------------
  // Pseudo-random source with time splicing
  // ----------------------------------------------------------------------
  assign prn_adv = prn_sel && !ins_q;

  tpg_prbs u_prbs (
    .clk(ref_clk),
    .rst_n(rst_n_q),
    .advance(prn_adv),
    .len_sel(prn_cfg.len_sel),
    .reverse(prn_cfg.reverse),
    .bit_out(prn_bit)
  );

  // Every gap of random bits, a snapshot of the time word goes out MSB first
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ins_q <= 1'b0;
      ins_idx_q <= 5'h00;
      time_q <= 32'h00000000;
      gap_q <= 11'h000;
    end else if (!prn_sel || !prn_cfg.insert_time) begin
      ins_q <= 1'b0; // [R4]
      gap_q <= 11'h000;
    end else if (ins_q) begin
      time_q <= time_q << 1;
      ins_idx_q <= ins_idx_q - 5'h01;
      ins_q <= (ins_idx_q != 5'h00);
    end else if (gap_q == TPG_TIME_GAP_BITS - 11'h001) begin
      gap_q <= 11'h000;
      ins_q <= 1'b1; // [R4]
      ins_idx_q <= 5'h1f;
      time_q <= irig_time;
    end else begin
      gap_q <= gap_q + 11'h001;
    end
  end

  // ----------------------------------------------------------------------
  // Output selection
  // ----------------------------------------------------------------------
  // One source drives the line at a time
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      tx_bit <= 1'b0;
      tx_valid <= 1'b0;
      frame_start <= 1'b0;
    end else begin
      frame_start <= (state_q == TPG_ST_SHIFT) && (word_idx_q == 13'h0001) &&
                     (bit_idx_q == 5'(cfg_q.bits_per_word - 5'h01));
      if (prn_sel) begin // [R5]
        tx_valid <= 1'b1;
        tx_bit <= ins_q ? time_q[31] : prn_bit;
      end else begin
        tx_valid <= running && (state_q == TPG_ST_SHIFT); // [R6]
        tx_bit <= running ? word_q[bit_idx_q[3:0]] : 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// ==== inc/tpg_pkg.sv ====
// Package of constants, types and helpers for the test pattern frame generator
`default_nettype none
package tpg_pkg;

  // ----------------------------------------------------------------------
  // Sizes and limits
  // ----------------------------------------------------------------------
  localparam int TPG_PROG_DEPTH = 32;
  localparam int TPG_PC_W = 5;
  localparam int TPG_LFSR_W = 31;
  localparam int TPG_TIME_W = 32;
  localparam logic [4:0] TPG_WIDTH_MIN = 5'h04;
  localparam logic [4:0] TPG_WIDTH_MAX = 5'h10;
  localparam logic [12:0] TPG_FLEN_MIN = 13'h0008;
  localparam logic [12:0] TPG_FLEN_MAX = 13'h1000;
  localparam logic [15:0] TPG_CMAX_MIN = 16'h0001;
  localparam logic [10:0] TPG_TIME_GAP_BITS = 11'h400;
  localparam logic [30:0] TPG_LFSR_SEED = 31'h7fffffff;
  localparam logic [15:0] TPG_CNT_RESET = 16'h0000;

  // ----------------------------------------------------------------------
  // Output source, sequence lengths, instructions, states
  // ----------------------------------------------------------------------
  typedef enum logic {TPG_SRC_PRN = 1'b0, TPG_SRC_PCM = 1'b1} tpg_src_e;

  typedef enum logic [2:0] {
    TPG_LEN_7 = 3'h0, TPG_LEN_9 = 3'h1, TPG_LEN_11 = 3'h2, TPG_LEN_15 = 3'h3,
    TPG_LEN_20 = 3'h4, TPG_LEN_23 = 3'h5, TPG_LEN_31 = 3'h6
  } tpg_len_e;

  typedef enum logic [2:0] {
    TPG_OP_FRAME_SYNC = 3'h0,  // frame_sync_word
    TPG_OP_IMMEDIATE = 3'h1,   // immediate_value_load
    TPG_OP_FRAME_COUNT = 3'h2, // frame_counter_word
    TPG_OP_GENERAL = 3'h3,
    TPG_OP_REPEAT = 3'h4
  } tpg_op_e;

  typedef enum logic [2:0] {
    TPG_ST_IDLE = 3'b001,
    TPG_ST_FETCH = 3'b010,
    TPG_ST_SHIFT = 3'b100
  } tpg_state_e;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    tpg_len_e len_sel;
    logic reverse;
    logic insert_time;
  } tpg_prn_cfg_s;

  typedef struct packed {
    logic [15:0] general_word;
    logic [4:0] bits_per_word;
    logic [12:0] words_per_frame;
    logic count_down;
    logic count_min;
    logic [15:0] count_max;
  } tpg_pcm_cfg_s;

  typedef struct packed {
    tpg_op_e op;
    logic [15:0] data;
  } tpg_instr_s;

  // ----------------------------------------------------------------------
  // Sequence length decode: register degree and feedback tap
  // ----------------------------------------------------------------------
  function automatic logic [4:0] tpg_degree(input tpg_len_e sel);
    unique case (sel)
      TPG_LEN_7: return 5'h07;
      TPG_LEN_9: return 5'h09;
      TPG_LEN_11: return 5'h0b;
      TPG_LEN_15: return 5'h0f;
      TPG_LEN_20: return 5'h14;
      TPG_LEN_23: return 5'h17;
      default: return 5'h1f;
    endcase
  endfunction

  function automatic logic [4:0] tpg_tap(input tpg_len_e sel);
    unique case (sel)
      TPG_LEN_7: return 5'h06;
      TPG_LEN_9: return 5'h05;
      TPG_LEN_11: return 5'h09;
      TPG_LEN_15: return 5'h0e;
      TPG_LEN_20: return 5'h11;
      TPG_LEN_23: return 5'h12;
      default: return 5'h1c;
    endcase
  endfunction

endpackage
`default_nettype wire
